// ==== logic/ppfs_defs.svh ====
// Constants for the port pin function select block
`ifndef PPFS_DEFS_SVH
`define PPFS_DEFS_SVH

// Register word indices, byte address is four times the index
`define PPFS_OFF_A_SEL     2'h0
`define PPFS_OFF_A_DIR     2'h1
`define PPFS_OFF_B_UPPER   2'h2
`define PPFS_OFF_B_LOWER   2'h3

// Reset values
`define PPFS_RST_WORD      16'h0000

// Writable bit masks
`define PPFS_A_SEL_MASK    16'h3FFF
`define PPFS_A_DIR_MASK    16'h3FF7

// Port A pin classes
`define PPFS_A_INV_MASK    14'h0080
`define PPFS_A_FIXED_MASK  14'h0008
`define PPFS_A_RSVD_MASK   14'h0001
`define PPFS_A_DRIVE_MASK  14'h019A

// Port A pin numbers
`define PPFS_PIN_RX_CLK    13
`define PPFS_PIN_RX_SYNC   12
`define PPFS_PIN_RX_DATA   11
`define PPFS_PIN_TX_CLK    10
`define PPFS_PIN_TX_SYNC   9
`define PPFS_PIN_TX_DATA   8
`define PPFS_PIN_WDT       7
`define PPFS_PIN_TMR_CLK   6
`define PPFS_PIN_CAPTURE   5
`define PPFS_PIN_CMP_A     4
`define PPFS_PIN_CLK_OUT   3
`define PPFS_PIN_LINK      2
`define PPFS_PIN_ETH_OUT   1

// Port B field code for general I/O
`define PPFS_B_GPIO        2'h0

// Bus answers
`define PPFS_RESP_OKAY     2'h0
`define PPFS_RESP_SLVERR   2'h2

`endif

// ==== logic/ppfs_pkg.sv ====
// Types for the port pin function select block
package ppfs_pkg;
	// Peripheral signals that drive port A pins
	typedef struct packed {
		logic tx_sync_out;
		logic tx_sync_drive;
		logic tx_data;
		logic wdt_overflow;
		logic cmp_out_a;
		logic cmp_out_b;
		logic periph_clock;
		logic eth_out;
	} ppfs_a_drv_t;
	// Port A pin levels delivered to peripherals
	typedef struct packed {
		logic rx_clock;
		logic rx_sync;
		logic rx_data;
		logic tx_clock;
		logic tx_sync_in;
		logic timer_clock;
		logic capture;
		logic link_status;
	} ppfs_a_rcv_t;
	// Port B peripheral lanes, one per non-zero field code
	typedef logic [3:1][15:0] ppfs_b_lanes_t;
endpackage

// ==== logic/ppfs_top.sv ====
// Port pin function select: registers, pin multiplexing, bus slave
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "ppfs_defs.svh"

module ppfs_top #(
	parameter int AW = 32
) (
	input  wire logic                  clock_i,
	input  wire logic                  reset_i,
	input  wire logic [AW-1:0]         s_axi_awaddr_i,
	input  wire logic                  s_axi_awvalid_i,
	output logic                       s_axi_awready_o,
	input  wire logic [31:0]           s_axi_wdata_i,
	input  wire logic [3:0]            s_axi_wstrb_i,
	input  wire logic                  s_axi_wvalid_i,
	output logic                       s_axi_wready_o,
	output logic [1:0]                 s_axi_bresp_o,
	output logic                       s_axi_bvalid_o,
	input  wire logic                  s_axi_bready_i,
	input  wire logic [AW-1:0]         s_axi_araddr_i,
	input  wire logic                  s_axi_arvalid_i,
	output logic                       s_axi_arready_o,
	output logic [31:0]                s_axi_rdata_o,
	output logic [1:0]                 s_axi_rresp_o,
	output logic                       s_axi_rvalid_o,
	input  wire logic                  s_axi_rready_i,
	input  wire logic [13:0]           a_pin_i,
	output logic [13:0]                a_pin_o,
	output logic [13:0]                a_pin_oe_n_o,
	input  wire logic [13:0]           a_data_i,
	output logic [13:0]                a_gpio_in_o,
	input  wire ppfs_pkg::ppfs_a_drv_t a_periph_i,
	output ppfs_pkg::ppfs_a_rcv_t      a_periph_o,
	input  wire logic [15:0]           b_pin_i,
	output logic [15:0]                b_pin_o,
	output logic [15:0]                b_pin_oe_n_o,
	input  wire logic [15:0]           b_data_i,
	input  wire logic [15:0]           b_dir_i,
	output logic [15:0]                b_gpio_in_o,
	input  wire ppfs_pkg::ppfs_b_lanes_t b_lane_out_i,
	input  wire ppfs_pkg::ppfs_b_lanes_t b_lane_drive_i,
	output ppfs_pkg::ppfs_b_lanes_t    b_lane_in_o
);

	// Address must reach the four register words
	if (AW < 4) begin : g_aw_check
		$error("ppfs_top: AW below 4");
	end

	// Register state
	logic [15:0]               a_sel;
	logic [15:0]               a_dir;
	logic [15:0]               b_upper;
	logic [15:0]               b_lower;
	logic [AW-1:0]             wr_addr;
	logic [31:0]               wr_data;
	logic [3:0]                wr_strb;

	// Decode: bit 2 hit, bits 1:0 word index
	function automatic logic [2:0] decode(input logic [AW-1:0] addr);
		decode = {(addr >> 4) == '0 && addr[1:0] == 2'h0, addr[3:2]};
	endfunction

	// Byte-lane merge of a 16-bit register under a writable mask
	function automatic logic [15:0] merge(
		input logic [15:0] old,
		input logic [31:0] data,
		input logic [3:0]  strb,
		input logic [15:0] mask
	);
		logic [15:0] lanes;
		lanes = {{8{strb[1]}}, {8{strb[0]}}} & mask;
		merge = (old & ~lanes) | (data[15:0] & lanes);
	endfunction

	// Bus decode
	wire  [2:0]  wr_dec  = decode(wr_addr);
	wire  [2:0]  rd_dec  = decode(s_axi_araddr_i);
	wire         do_write = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
	wire         wr_hit  = do_write && wr_dec[2];
	wire         rd_take = s_axi_arvalid_i && s_axi_arready_o;

	// Read selection, bits outside the writable masks read as zero, reserved pin 0 bits read back as written
	logic [15:0] rd_word;
	always_comb begin
		case (rd_dec[1:0])
			`PPFS_OFF_A_SEL:   rd_word = a_sel & `PPFS_A_SEL_MASK;
			`PPFS_OFF_A_DIR:   rd_word = a_dir & `PPFS_A_DIR_MASK;
			`PPFS_OFF_B_UPPER: rd_word = b_upper;
			`PPFS_OFF_B_LOWER: rd_word = b_lower;
			default:           rd_word = `PPFS_RST_WORD;
		endcase
	end

	// Write channel handshakes and response
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o  <= 1'b1;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= `PPFS_RESP_OKAY;
			wr_addr         <= '0;
			wr_data         <= '0;
			wr_strb         <= '0;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				wr_addr         <= s_axi_awaddr_i;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				wr_data        <= s_axi_wdata_i;
				wr_strb        <= s_axi_wstrb_i;
				s_axi_wready_o <= 1'b0;
			end
			if (do_write) begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= wr_dec[2] ? `PPFS_RESP_OKAY : `PPFS_RESP_SLVERR;
			end
			if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o  <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o  <= 1'b1;
			end
		end
	end

	// Read channel, answer at the edge after the address is taken
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= '0;
			s_axi_rresp_o   <= `PPFS_RESP_OKAY;
		end else if (rd_take) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b1;
			s_axi_rdata_o   <= {16'h0000, rd_dec[2] ? rd_word : `PPFS_RST_WORD};
			s_axi_rresp_o   <= rd_dec[2] ? `PPFS_RESP_OKAY : `PPFS_RESP_SLVERR;
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o  <= 1'b0;
			s_axi_arready_o <= 1'b1;
		end
	end

	// Configuration registers, cleared only by the power-on reset input
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			a_sel   <= `PPFS_RST_WORD;
			a_dir   <= `PPFS_RST_WORD;
			b_upper <= `PPFS_RST_WORD;
			b_lower <= `PPFS_RST_WORD;
		end else if (wr_hit) begin
			case (wr_dec[1:0])
				`PPFS_OFF_A_SEL:   a_sel   <= merge(a_sel, wr_data, wr_strb,
				                                    `PPFS_A_SEL_MASK);
				`PPFS_OFF_A_DIR:   a_dir   <= merge(a_dir, wr_data, wr_strb,
				                                    `PPFS_A_DIR_MASK);
				`PPFS_OFF_B_UPPER: b_upper <= merge(b_upper, wr_data, wr_strb, 16'hFFFF);
				`PPFS_OFF_B_LOWER: b_lower <= merge(b_lower, wr_data, wr_strb, 16'hFFFF);
				default:           a_sel   <= a_sel;
			endcase
		end
	end

	// Port A ownership: bit 7 inverted, bit 3 always peripheral, bit 0 reserved
	wire  [13:0] a_own = ((a_sel[13:0] ^ `PPFS_A_INV_MASK) | `PPFS_A_FIXED_MASK)
	                     & ~`PPFS_A_RSVD_MASK;

	// Port A peripheral output values per pin
	wire  [13:0] a_per_out = {
		4'h0,
		a_periph_i.tx_sync_out,
		a_periph_i.tx_data,
		a_periph_i.wdt_overflow,
		2'h0,
		a_periph_i.cmp_out_a,
		a_sel[`PPFS_PIN_CLK_OUT] ? a_periph_i.cmp_out_b
		                         : a_periph_i.periph_clock,
		1'b0,
		a_periph_i.eth_out,
		1'b0
	};

	// Port A peripheral drive per pin, transmit sync follows its owner
	wire  [13:0] a_per_drv = `PPFS_A_DRIVE_MASK
	                         | {4'h0, a_periph_i.tx_sync_drive, 9'h000};

	// Pin value and enable: peripheral or general I/O with direction
	wire  [13:0] next_a_pin = (a_own & a_per_out) | (~a_own & a_data_i);
	wire  [13:0] next_a_drv = (a_own & a_per_drv) | (~a_own & a_dir[13:0]);
	wire  [13:0] a_rx       = a_pin_i & a_own;

	// Port A pin levels handed to their peripherals
	ppfs_pkg::ppfs_a_rcv_t next_a_rcv;
	assign next_a_rcv.rx_clock    = a_rx[`PPFS_PIN_RX_CLK];
	assign next_a_rcv.rx_sync     = a_rx[`PPFS_PIN_RX_SYNC];
	assign next_a_rcv.rx_data     = a_rx[`PPFS_PIN_RX_DATA];
	assign next_a_rcv.tx_clock    = a_rx[`PPFS_PIN_TX_CLK];
	assign next_a_rcv.tx_sync_in  = a_rx[`PPFS_PIN_TX_SYNC];
	assign next_a_rcv.timer_clock = a_rx[`PPFS_PIN_TMR_CLK];
	assign next_a_rcv.capture     = a_rx[`PPFS_PIN_CAPTURE];
	assign next_a_rcv.link_status = a_rx[`PPFS_PIN_LINK];

	// Port B fields: upper register pins 15..8, lower pins 7..0
	wire  [31:0] b_fields = {b_upper, b_lower};

	// Port B per-pin selection
	logic [15:0]             next_b_pin;
	logic [15:0]             next_b_drv;
	ppfs_pkg::ppfs_b_lanes_t next_b_rcv;
	always_comb begin
		logic [1:0] code;
		code       = `PPFS_B_GPIO;
		next_b_pin = '0;
		next_b_drv = '0;
		next_b_rcv = '0;
		for (int i = 0; i < 16; i++) begin
			code = b_fields[2*i +: 2];
			if (code == `PPFS_B_GPIO) begin
				next_b_pin[i] = b_data_i[i];
				next_b_drv[i] = b_dir_i[i];
			end else begin
				next_b_pin[i]       = b_lane_out_i[code][i];
				next_b_drv[i]       = b_lane_drive_i[code][i];
				next_b_rcv[code][i] = b_pin_i[i];
			end
		end
	end

	// Registered pin side outputs
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			a_pin_o      <= '0;
			a_pin_oe_n_o <= '1;
			a_gpio_in_o  <= '0;
			a_periph_o   <= '0;
			b_pin_o      <= '0;
			b_pin_oe_n_o <= '1;
			b_gpio_in_o  <= '0;
			b_lane_in_o  <= '0;
		end else begin
			a_pin_o      <= next_a_pin;
			a_pin_oe_n_o <= ~next_a_drv;
			a_gpio_in_o  <= a_pin_i;
			a_periph_o   <= next_a_rcv;
			b_pin_o      <= next_b_pin;
			b_pin_oe_n_o <= ~next_b_drv;
			b_gpio_in_o  <= b_pin_i;
			b_lane_in_o  <= next_b_rcv;
		end
	end

	// Checks
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);

	sequence rd_taken;
		s_axi_arvalid_i && s_axi_arready_o;
	endsequence
	sequence rd_answered;
		s_axi_rvalid_o && !s_axi_arready_o;
	endsequence

	read_answer_a: assert property (rd_taken |=> rd_answered)
		else $error("read not answered next cycle");

	reset_clear_a: assert property ($past(reset_i) |->
		a_sel == `PPFS_RST_WORD && a_dir == `PPFS_RST_WORD
		&& b_upper == `PPFS_RST_WORD && b_lower == `PPFS_RST_WORD)
		else $error("registers not cleared by reset");

	rx_clock_route_a: assert property (a_sel[13] |=>
		a_periph_o.rx_clock == $past(a_pin_i[13]) && a_pin_oe_n_o[13])
		else $error("receive clock not routed");

	wdt_default_a: assert property (!a_sel[7] |=>
		a_pin_o[7] == $past(a_periph_i.wdt_overflow) && !a_pin_oe_n_o[7])
		else $error("watchdog overflow not on pin 7");

	pin3_output_a: assert property (1'b1 |=>
		!a_pin_oe_n_o[3] && a_pin_o[3] == ($past(a_sel[3]) ? $past(a_periph_i.cmp_out_b)
		                                                   : $past(a_periph_i.periph_clock)))
		else $error("pin 3 not peripheral output");

	gpio_dir_a: assert property (!a_sel[12] |=>
		a_pin_oe_n_o[12] == !$past(a_dir[12]) && a_pin_o[12] == $past(a_data_i[12]))
		else $error("general I/O direction wrong");

	dir_ignored_a: assert property (a_sel[8] && !a_dir[8] |=> !a_pin_oe_n_o[8])
		else $error("direction not ignored");

	reserved_zero_a: assert property (s_axi_rvalid_o |->
		s_axi_rdata_o[31:16] == 16'h0000 && (a_dir & ~`PPFS_A_DIR_MASK) == 16'h0000
		&& (a_sel & ~`PPFS_A_SEL_MASK) == 16'h0000)
		else $error("reserved bits not zero");

	b_gpio_a: assert property (b_upper[15:14] == 2'h0 |=>
		b_pin_o[15] == $past(b_data_i[15]) && b_pin_oe_n_o[15] == !$past(b_dir_i[15]))
		else $error("port B field 00 not general I/O");

	b_lane_a: assert property (b_lower[1:0] != `PPFS_B_GPIO |=>
		b_pin_o[0] == $past(b_lane_out_i[b_lower[1:0]][0])
		&& b_lane_in_o[$past(b_lower[1:0])][0] == $past(b_pin_i[0]))
		else $error("port B lane not routed");

endmodule

// ==== verification/ppfs_partner.sv ====
// Peripheral and package pin model on the far side of the pin mux
`timescale 1ns/10ps

module ppfs_partner (
	input  wire logic [13:0]           a_out_i,
	input  wire logic [13:0]           a_oe_n_i,
	input  wire logic [13:0]           a_ext_i,
	input  wire logic [15:0]           b_out_i,
	input  wire logic [15:0]           b_oe_n_i,
	output logic [13:0]                a_level_o,
	output logic [15:0]                b_level_o,
	output ppfs_pkg::ppfs_a_drv_t      a_drv_o,
	output ppfs_pkg::ppfs_b_lanes_t    b_lane_out_o,
	output ppfs_pkg::ppfs_b_lanes_t    b_lane_drive_o
);
	// Undriven port B pins see a board pattern
	localparam logic [15:0] B_EXT = 16'h5A5A;

	// Wire level: device where enabled, board otherwise
	assign a_level_o = (a_out_i & ~a_oe_n_i) | (a_ext_i & a_oe_n_i);
	assign b_level_o = (b_out_i & ~b_oe_n_i) | (B_EXT & b_oe_n_i);

	// Peripheral outputs: fixed levels, compare B low to tell it from clock out
	assign a_drv_o = 8'hFB;
	assign b_lane_out_o = {16'hFFFF, 16'h0000, 16'hFFFF};
	assign b_lane_drive_o = {16'hFFFF, 16'hFFFF, 16'hFFFF};
endmodule

// ==== verification/ppfs_top_test.sv ====
// Register and pin routing tests for the port pin function select block
`timescale 1ns/10ps

module ppfs_top_test;
	logic                    clock_i = 1'b0;
	logic                    reset_i = 1'b1;
	logic [31:0]             awaddr  = 32'h0;
	logic                    awvalid = 1'b0;
	logic [31:0]             wdata   = 32'h0;
	logic                    wvalid  = 1'b0;
	logic                    bready  = 1'b0;
	logic [31:0]             araddr  = 32'h0;
	logic                    arvalid = 1'b0;
	logic                    rready  = 1'b0;
	logic [13:0]             a_data  = 14'h0000;
	logic [13:0]             a_ext   = 14'h1445;
	logic [15:0]             b_data  = 16'h0000;
	logic [15:0]             b_gin;
	logic                    awready, wready, bvalid, arready, rvalid;
	logic [1:0]              bresp, rresp, resp;
	logic [31:0]             rdata, rd_val;
	logic [13:0]             a_pin, a_out, a_oe_n, a_gin;
	logic [15:0]             b_pin, b_out, b_oe_n;
	ppfs_pkg::ppfs_a_drv_t   a_drv;
	ppfs_pkg::ppfs_a_rcv_t   a_rcv;
	ppfs_pkg::ppfs_b_lanes_t b_lo, b_ld, b_li;
	int                      n_errors = 0;
	int                      checks = 0;

	ppfs_top ppfs_top_i (.clock_i(clock_i), .reset_i(reset_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.a_pin_i(a_pin), .a_pin_o(a_out), .a_pin_oe_n_o(a_oe_n), .a_data_i(a_data),
		.a_gpio_in_o(a_gin), .a_periph_i(a_drv), .a_periph_o(a_rcv),
		.b_pin_i(b_pin), .b_pin_o(b_out), .b_pin_oe_n_o(b_oe_n), .b_data_i(b_data),
		.b_dir_i(16'hFFFF), .b_gpio_in_o(b_gin), .b_lane_out_i(b_lo),
		.b_lane_drive_i(b_ld), .b_lane_in_o(b_li));

	ppfs_partner ppfs_partner_i (.a_out_i(a_out), .a_oe_n_i(a_oe_n), .a_ext_i(a_ext),
		.b_out_i(b_out), .b_oe_n_i(b_oe_n), .a_level_o(a_pin), .b_level_o(b_pin),
		.a_drv_o(a_drv), .b_lane_out_o(b_lo), .b_lane_drive_o(b_ld));

	// 20 MHz clock
	initial begin
		forever #25 clock_i = ~clock_i;
	end

	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict;
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// Power-on reset held for 20 cycles
	task automatic por;
		reset_i <= 1'b1;
		repeat (20) @(posedge clock_i);
		reset_i <= 1'b0;
		@(posedge clock_i);
	endtask

	// AXI4-Lite write, bready held until bvalid sampled, then one idle edge
	task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clock_i);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		r = bresp;
		bready <= 1'b0;
		@(posedge clock_i);
	endtask

	// AXI4-Lite read, rready held until rvalid sampled, then one idle edge
	task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clock_i);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge clock_i);
	endtask

	// Read a register and expect OKAY with a value
	task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
		rd(a, rd_val, resp);
		chk(32'(resp), 32'h0);
		chk(rd_val, exp);
	endtask

	task automatic wok(input logic [31:0] a, input logic [31:0] d);
		wr(a, d, resp);
		chk(32'(resp), 32'h0);
	endtask

	// Let registered pin outputs follow the new setup
	task automatic settle;
		repeat (4) @(posedge clock_i);
	endtask

	// Main sequence
	initial begin
		por();
		rchk(32'h0, 32'h0);
		rchk(32'h4, 32'h0);
		rchk(32'h8, 32'h0);
		rchk(32'hC, 32'h0);
		settle();
		chk(32'(a_oe_n), 32'h3F77);
		chk(32'(a_out & ~a_oe_n), 32'h0088);
		chk(32'(b_out | b_oe_n), 32'h0000);
		chk(32'(a_rcv), 32'h0);
		$display("test reset state done");
		wok(32'h0, 32'h0000_3FFE);
		rchk(32'h0, 32'h3FFE);
		wok(32'h4, 32'hFFFF_FFFF);
		rchk(32'h4, 32'h3FF7);
		wok(32'h8, 32'h0000_E400);
		wok(32'hC, 32'h0000_001B);
		rchk(32'h8, 32'hE400);
		rchk(32'hC, 32'h001B);
		settle();
		chk(32'(a_oe_n), 32'h3C64);
		chk(32'(a_out & ~a_oe_n), 32'h0312);
		chk(32'(a_gin), 32'h1756);
		chk(32'(a_rcv), 32'h5D);
		chk(32'(b_oe_n), 32'h0000);
		chk(32'(b_out), 32'hA005);
		chk(32'(b_li[3]), 32'h8001);
		$display("test all functions done");
		wok(32'h0, 32'h0);
		a_data <= 14'h1555;
		b_data <= 16'h1234;
		settle();
		chk(32'(a_oe_n), 32'h0000);
		chk(32'(a_out), 32'h15DD);
		chk(32'(b_out), 32'hB235);
		chk(32'(b_gin), 32'hB235);
		$display("test general io done");
		wr(32'h10, 32'h1, resp);
		chk(32'(resp), 32'h2);
		rd(32'h2, rd_val, resp);
		chk(32'(resp), 32'h2);
		chk(rd_val, 32'h0);
		rchk(32'h0, 32'h0);
		$display("test unmapped done");
		por();
		rchk(32'h4, 32'h0);
		rchk(32'h8, 32'h0);
		rchk(32'hC, 32'h0);
		$display("test second reset done");
		print_verdict();
	end

	// Watchdog
	initial begin
		#(5000 * 50);
		n_errors++;
		print_verdict();
	end
endmodule
